// ---- logic/wdt_top.sv ----
// Watchdog timer: time-out counter, flags, timed-access guard and register port
`include "wdt_map.svh"
module wdt_top
   import wdt_pkg::*;
#(
   parameter int CNT_W = 27,
   parameter int EXP0 = `WDT_EXP_SEL0,
   parameter int EXP1 = `WDT_EXP_SEL1,
   parameter int EXP2 = `WDT_EXP_SEL2,
   parameter int EXP3 = `WDT_EXP_SEL3,
   parameter int EARLY = `WDT_EARLY_CLKS
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Special function register port
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   // Watchdog outputs
   output logic WDT_IRQ,
   output logic WDT_WAKE,
   output logic WDT_CPU_RESET
);
   logic [7:0] clksel_r;
   logic irq_en_r;
   logic [7:0] xie_rest_r;
   logic rst_en_r;
   logic irq_flag_r;
   logic rst_flag_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] irq_at;
   logic [CNT_W-1:0] rst_at;
   logic ta_open;
   logic wr_ctrl;
   logic restart;
   logic hit_irq;
   logic hit_rst;
   logic [7:0] rdata_nxt;

   // Time-out for a select code, shared by both thresholds
   function automatic logic [CNT_W-1:0] tmo(input logic [1:0] sel);
      logic [CNT_W-1:0] one;
      one = CNT_W'(1);
      unique case (sel)
         2'b00: tmo = one << EXP0;
         2'b01: tmo = one << EXP1;
         2'b10: tmo = one << EXP2;
         2'b11: tmo = one << EXP3;
      endcase
   endfunction

   // Timed-access guard for protected bits
   wdt_unlock #(.WINDOW(`WDT_TA_WINDOW)) u_unlock (
      .MCLK(MCLK),
      .RST(RST),
      .wr_en(SFR_WR),
      .wr_addr(SFR_ADDR),
      .wr_data(SFR_WDATA),
      .open_o(ta_open)
   );

   assign wr_ctrl = SFR_WR && SFR_ADDR == `WDT_ADDR_CTRL;
   // Restart only honoured while unlocked
   assign restart = wr_ctrl && ta_open && SFR_WDATA[`WDT_BIT_RESTART];
   // Select bits 7 and 6, bit 7 the upper
   assign irq_at = tmo({clksel_r[`WDT_BIT_SEL_HI], clksel_r[`WDT_BIT_SEL_LO]});
   assign rst_at = irq_at + CNT_W'(EARLY);
   assign hit_irq = cnt_r == irq_at;
   assign hit_rst = cnt_r == rst_at;

   // Clock control register; timer speed bits stored for the core
   always_ff @(posedge MCLK) begin
      if (RST) begin
         clksel_r <= `WDT_RESET_CLKSEL;
      end else if (SFR_WR && SFR_ADDR == `WDT_ADDR_CLKSEL) begin
         clksel_r <= SFR_WDATA;
      end
   end

   // Extended interrupt enable; only the watchdog bit acts here
   always_ff @(posedge MCLK) begin
      if (RST) begin
         irq_en_r <= 1'b0;
         xie_rest_r <= `WDT_RESET_XIE;
      end else if (SFR_WR && SFR_ADDR == `WDT_ADDR_XIE) begin
         irq_en_r <= SFR_WDATA[`WDT_BIT_IRQ_EN];
         xie_rest_r <= SFR_WDATA;
      end
   end

   // Reset enable, guarded; plain writes are dropped silently
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rst_en_r <= 1'b0;
      end else if (wr_ctrl && ta_open) begin
         rst_en_r <= SFR_WDATA[`WDT_BIT_RST_EN];
      end
   end

   // Counter runs every oscillator clock, saturating after reset point
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cnt_r <= '0;
      end else if (restart) begin
         cnt_r <= '0;
      end else if (!hit_rst) begin
         cnt_r <= cnt_r + CNT_W'(1);
      end
   end

   // Sticky flags; a hit in the clearing cycle wins over the clear unless that write also restarts
   always_ff @(posedge MCLK) begin
      if (RST) begin
         irq_flag_r <= 1'b0;
         rst_flag_r <= 1'b0;
      end else begin
         if (hit_irq && !restart) begin
            irq_flag_r <= 1'b1;
         end else if (wr_ctrl && !SFR_WDATA[`WDT_BIT_IRQ_FLAG]) begin
            irq_flag_r <= 1'b0;
         end
         if (hit_rst && !restart) begin
            rst_flag_r <= 1'b1;
         end else if (wr_ctrl && !SFR_WDATA[`WDT_BIT_RST_FLAG]) begin
            rst_flag_r <= 1'b0;
         end
      end
   end

   // Interrupt independent of reset enable; also the wake source
   assign WDT_IRQ = irq_flag_r && irq_en_r;
   assign WDT_WAKE = WDT_IRQ;
   // CPU reset held from expiry until restart when enabled
   assign WDT_CPU_RESET = rst_en_r && hit_rst && !restart;

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = 8'h00;
      unique case (SFR_ADDR)
         `WDT_ADDR_CLKSEL: rdata_nxt = clksel_r;
         `WDT_ADDR_CTRL: begin
            rdata_nxt[`WDT_BIT_IRQ_FLAG] = irq_flag_r;
            rdata_nxt[`WDT_BIT_RST_FLAG] = rst_flag_r;
            rdata_nxt[`WDT_BIT_RST_EN] = rst_en_r;
         end
         `WDT_ADDR_XIE: begin
            rdata_nxt = xie_rest_r;
            rdata_nxt[`WDT_BIT_IRQ_EN] = irq_en_r;
         end
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Registered read data, one cycle after the read strobe
   always_ff @(posedge MCLK) begin
      if (RST) begin
         SFR_RDATA <= 8'h00;
      end else if (SFR_RD) begin
         SFR_RDATA <= rdata_nxt;
      end
   end

   // Checker helper: cycles since the interrupt point, frozen at the reset point.
   // Kept apart from the main counter so a skipped count shows up as a wrong gap.
   logic [CNT_W-1:0] gap_r;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         gap_r <= '0;
      end else if (restart) begin
         gap_r <= '0;
      end else if (hit_irq) begin
         gap_r <= CNT_W'(1);
      end else if (gap_r != '0 && !hit_rst) begin
         gap_r <= gap_r + CNT_W'(1);
      end
   end

   // Interrupt flag sets at the selected time-out
   a_irq_sets: assert property (@(posedge MCLK) disable iff (RST)
      hit_irq && !restart |=> irq_flag_r)
      else $error("interrupt flag missed at time-out");
   a_restart_zero: assert property (@(posedge MCLK) disable iff (RST)
      restart |=> cnt_r == '0)
      else $error("restart did not clear counter");

   // Reset output follows the expiry only while the function is enabled
   a_reset_out: assert property (@(posedge MCLK) disable iff (RST)
      $rose(rst_flag_r) && rst_en_r && !restart |-> WDT_CPU_RESET)
      else $error("cpu reset missing at expiry");
   a_reset_off: assert property (@(posedge MCLK) disable iff (RST)
      !rst_en_r |-> !WDT_CPU_RESET)
      else $error("cpu reset while function disabled");

   // Guarded bits never move while locked
   a_guard_en: assert property (@(posedge MCLK) disable iff (RST)
      !$past(ta_open) && !$stable(rst_en_r) |-> 1'b0)
      else $error("reset enable changed while locked");
   a_guard_restart: assert property (@(posedge MCLK) disable iff (RST)
      wr_ctrl && !ta_open |=> cnt_r != '0)
      else $error("locked write restarted the counter");

   // Interrupt flag leads the reset flag by the early gap
   a_early_gap: assert property (@(posedge MCLK) disable iff (RST)
      hit_rst && !$past(hit_rst) && gap_r != '0 |-> gap_r == CNT_W'(EARLY))
      else $error("early interrupt gap wrong");
   a_rst_sets: assert property (@(posedge MCLK) disable iff (RST)
      hit_rst && !restart |=> rst_flag_r)
      else $error("reset flag missed at expiry");
   a_gap_order: assert property (@(posedge MCLK) disable iff (RST)
      rst_at > irq_at)
      else $error("reset point not after interrupt point");

   // Interrupt request gated by its own enable, blind to reset enable
   a_irq_gate: assert property (@(posedge MCLK) disable iff (RST)
      irq_flag_r && irq_en_r |-> WDT_IRQ)
      else $error("interrupt not raised when enabled");
   a_irq_off: assert property (@(posedge MCLK) disable iff (RST)
      !irq_en_r |-> !WDT_IRQ)
      else $error("interrupt raised while masked");
   a_irq_indep: assert property (@(posedge MCLK) disable iff (RST)
      $changed(rst_en_r) && $stable(irq_flag_r) && $stable(irq_en_r) |-> $stable(WDT_IRQ))
      else $error("interrupt moved with reset enable");
   a_wake_tracks: assert property (@(posedge MCLK) disable iff (RST)
      WDT_WAKE == WDT_IRQ)
      else $error("wake differs from interrupt");

   // Select decode, bit 7 the upper select bit
   a_sel_code0: assert property (@(posedge MCLK) disable iff (RST)
      clksel_r[7:6] == 2'b00 |-> irq_at == CNT_W'(1) << EXP0)
      else $error("time-out for code 0 wrong");
   a_sel_code1: assert property (@(posedge MCLK) disable iff (RST)
      clksel_r[7:6] == 2'b01 |-> irq_at == CNT_W'(1) << EXP1)
      else $error("time-out for code 1 wrong");
   a_sel_code2: assert property (@(posedge MCLK) disable iff (RST)
      clksel_r[7:6] == 2'b10 |-> irq_at == CNT_W'(1) << EXP2)
      else $error("time-out for code 2 wrong");
   a_sel_code3: assert property (@(posedge MCLK) disable iff (RST)
      clksel_r[7:6] == 2'b11 |-> irq_at == CNT_W'(1) << EXP3)
      else $error("time-out for code 3 wrong");

   // Flags hold where nothing moves them; counter advances until the reset point
   a_flag_hold: assert property (@(posedge MCLK) disable iff (RST)
      irq_flag_r && !wr_ctrl |=> irq_flag_r)
      else $error("interrupt flag dropped by itself");
   a_count_runs: assert property (@(posedge MCLK) disable iff (RST)
      !restart && !hit_rst |=> cnt_r == $past(cnt_r) + CNT_W'(1))
      else $error("counter failed to advance");
   c_irq: cover property (@(posedge MCLK) $rose(irq_flag_r));
   c_reset: cover property (@(posedge MCLK) WDT_CPU_RESET);
   a_rst_hold: assert property (@(posedge MCLK) disable iff (RST)
      rst_flag_r && !wr_ctrl |=> rst_flag_r)
      else $error("reset flag dropped by itself");
   a_irq_clear: assert property (@(posedge MCLK) disable iff (RST)
      wr_ctrl && !SFR_WDATA[`WDT_BIT_IRQ_FLAG] && !hit_irq |=> !irq_flag_r)
      else $error("interrupt flag not cleared by write");
   a_sel_kept: assert property (@(posedge MCLK) disable iff (RST)
      restart |=> $stable(clksel_r))
      else $error("restart altered the selection");
   a_count_stop: assert property (@(posedge MCLK) disable iff (RST)
      hit_rst && !restart |=> cnt_r == $past(cnt_r))
      else $error("counter ran past the reset point");

   // Read data loads on the strobe and holds otherwise
   a_rdata_load: assert property (@(posedge MCLK) disable iff (RST)
      SFR_RD |=> SFR_RDATA == $past(rdata_nxt))
      else $error("read data not loaded");
   a_rdata_hold: assert property (@(posedge MCLK) disable iff (RST)
      !SFR_RD |=> $stable(SFR_RDATA))
      else $error("read data changed without a read");
   a_restart_reads0: assert property (@(posedge MCLK) disable iff (RST)
      SFR_RD && SFR_ADDR == `WDT_ADDR_CTRL |=> !SFR_RDATA[`WDT_BIT_RESTART])
      else $error("restart bit read back as one");

   c_restart: cover property (@(posedge MCLK) restart);
   c_wake: cover property (@(posedge MCLK) WDT_WAKE);
   c_locked_write: cover property (@(posedge MCLK) wr_ctrl && !ta_open);
endmodule

// ---- logic/wdt_map.svh ----
// Register addresses, field positions, reset values and timing counts for the watchdog
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_ADDR_CLKSEL 8'h8E
`define WDT_ADDR_CTRL 8'hD8
`define WDT_ADDR_XIE 8'hE8
`define WDT_ADDR_TA 8'hC7
`define WDT_BIT_SEL_HI 7
`define WDT_BIT_SEL_LO 6
`define WDT_BIT_IRQ_FLAG 3
`define WDT_BIT_RST_FLAG 2
`define WDT_BIT_RST_EN 1
`define WDT_BIT_RESTART 0
`define WDT_BIT_IRQ_EN 6
`define WDT_RESET_CLKSEL 8'h00
`define WDT_RESET_CTRL 8'h00
`define WDT_RESET_XIE 8'h00
`define WDT_TA_KEY1 8'hAA
`define WDT_TA_KEY2 8'h55
`define WDT_TA_WINDOW 3
`define WDT_EARLY_CLKS 512
`define WDT_EXP_SEL0 17
`define WDT_EXP_SEL1 20
`define WDT_EXP_SEL2 23
`define WDT_EXP_SEL3 26
`endif

// ---- logic/wdt_pkg.sv ----
// Types shared by the watchdog design
package wdt_pkg;
   typedef enum logic [1:0] {
      WDT_TA_IDLE,
      WDT_TA_KEYED,
      WDT_TA_OPEN
   } wdt_ta_state_t;
endpackage

// ---- logic/wdt_unlock.sv ----
// Timed-access unlock sequencer guarding protected watchdog bits
`include "wdt_map.svh"
module wdt_unlock
   import wdt_pkg::*;
#(
   parameter int WINDOW = `WDT_TA_WINDOW
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Register write strobe
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Unlock state
   output logic open_o
);
   wdt_ta_state_t state_r;
   logic [3:0] cnt_r;

   // Two keys in order, then a short window for one protected write
   always_ff @(posedge MCLK) begin
      if (RST) begin
         state_r <= WDT_TA_IDLE;
         cnt_r <= 4'h0;
      end else begin
         unique case (state_r)
            WDT_TA_IDLE: begin
               if (wr_en && wr_addr == `WDT_ADDR_TA && wr_data == `WDT_TA_KEY1) begin
                  state_r <= WDT_TA_KEYED;
                  cnt_r <= 4'(WINDOW);
               end
            end
            WDT_TA_KEYED: begin
               if (wr_en && wr_addr == `WDT_ADDR_TA && wr_data == `WDT_TA_KEY2) begin
                  state_r <= WDT_TA_OPEN;
                  cnt_r <= 4'(WINDOW);
               end else if (wr_en || cnt_r == 4'h0) begin
                  state_r <= WDT_TA_IDLE;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            WDT_TA_OPEN: begin
               // Any write or the window expiring relocks; a single shot only
               if (wr_en || cnt_r == 4'h0) begin
                  state_r <= WDT_TA_IDLE;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
         endcase
      end
   end

   assign open_o = (state_r == WDT_TA_OPEN);

   a_key_order: assert property (@(posedge MCLK) disable iff (RST)
      $rose(open_o) |-> $past(state_r) == WDT_TA_KEYED)
      else $error("unlock opened without first key");
endmodule

// ---- tb/watchdog_timeout_unit_bench.sv ----
// Self-checking bench for the watchdog time-out unit
`include "wdt_map.svh"
`define CHK(what, exp, got) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      err_total++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
   end \
end
module watchdog_timeout_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EARLY = 8;
   // Short exponents keep every time-out within a few hundred clocks
   localparam int EXPS [4] = '{4, 5, 6, 7};
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic SFR_WR = 1'b0;
   logic SFR_RD = 1'b0;
   logic [7:0] SFR_ADDR = 8'h00;
   logic [7:0] SFR_WDATA = 8'h00;
   logic [7:0] SFR_RDATA;
   logic WDT_IRQ;
   logic WDT_WAKE;
   logic WDT_CPU_RESET;
   int n_tests = 0;
   int err_total = 0;
   logic [7:0] d;
   int c;
   int c2;

   wdt_top #(.CNT_W(27), .EXP0(4), .EXP1(5), .EXP2(6), .EXP3(7), .EARLY(EARLY)) dut (
      .MCLK(MCLK), .RST(RST), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_ADDR(SFR_ADDR),
      .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .WDT_IRQ(WDT_IRQ),
      .WDT_WAKE(WDT_WAKE), .WDT_CPU_RESET(WDT_CPU_RESET));

   // Free-running oscillator clock, 8 ns period
   initial begin
      forever #4 MCLK = ~MCLK;
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One-cycle write strobe; an idle cycle always follows
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge MCLK);
      SFR_WR = 1'b1;
      SFR_ADDR = a;
      SFR_WDATA = v;
      @(negedge MCLK);
      SFR_WR = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge MCLK);
      SFR_RD = 1'b1;
      SFR_ADDR = a;
      @(negedge MCLK);
      SFR_RD = 1'b0;
      v = SFR_RDATA;
   endtask

   // Key pair then the guarded control write, all inside the window
   task automatic unlock_wr(input logic [7:0] v);
      wr(`WDT_ADDR_TA, `WDT_TA_KEY1);
      wr(`WDT_ADDR_TA, `WDT_TA_KEY2);
      wr(`WDT_ADDR_CTRL, v);
   endtask

   // Bounded wait; a hang counts as a mismatch and ends the run
   task automatic wait_out(input bit which, output int n);
      n = 0;
      while ((which ? WDT_CPU_RESET : WDT_IRQ) !== 1'b1) begin
         @(negedge MCLK);
         n++;
         if (n > 400) begin
            err_total++;
            give_verdict();
         end
      end
   endtask

   task automatic t_reset();
      rd(`WDT_ADDR_CTRL, d);
      `CHK("ctrl reset", 8'h00, d)
      rd(`WDT_ADDR_CLKSEL, d);
      `CHK("clksel reset", 8'h00, d)
      rd(`WDT_ADDR_XIE, d);
      `CHK("xie reset", 8'h00, d)
      rd(8'h01, d);
      `CHK("unmapped read", 8'h00, d)
   endtask

   // Guarded bits refused without keys and after an interrupted key pair
   task automatic t_lock();
      wr(`WDT_ADDR_CTRL, 8'h03);
      rd(`WDT_ADDR_CTRL, d);
      `CHK("locked enable", 1'b0, d[1])
      wr(`WDT_ADDR_TA, `WDT_TA_KEY1);
      wr(`WDT_ADDR_CLKSEL, 8'h00);
      wr(`WDT_ADDR_TA, `WDT_TA_KEY2);
      wr(`WDT_ADDR_CTRL, 8'h03);
      rd(`WDT_ADDR_CTRL, d);
      `CHK("aborted unlock", 1'b0, d[1])
   endtask

   // Every select code: interrupt point, early gap, held CPU reset
   task automatic t_timeout();
      for (int s = 0; s < 4; s++) begin
         wr(`WDT_ADDR_CLKSEL, 8'(s << 6));
         rd(`WDT_ADDR_CLKSEL, d);
         `CHK("select field", 8'(s << 6), d)
         wr(`WDT_ADDR_XIE, 8'h40);
         unlock_wr(8'h03);
         wait_out(1'b0, c);
         `CHK("irq delay", 1'b1, c >= (1 << EXPS[s]) - 2 && c <= (1 << EXPS[s]) + 2)
         wait_out(1'b1, c2);
         `CHK("early gap", 1'b1, c2 >= EARLY - 1 && c2 <= EARLY + 1)
         repeat (20) @(negedge MCLK);
         `CHK("cpu reset held", 1'b1, WDT_CPU_RESET)
         rd(`WDT_ADDR_CTRL, d);
         `CHK("sticky flags", 8'h0E, d)
         unlock_wr(8'h01);
         `CHK("cpu reset cleared", 1'b0, WDT_CPU_RESET)
      end
   endtask

   // A second restart midway pushes the time-out out again
   task automatic t_restart();
      wr(`WDT_ADDR_CLKSEL, 8'h40);
      unlock_wr(8'h01);
      repeat (20) @(negedge MCLK);
      unlock_wr(8'h01);
      wait_out(1'b0, c);
      `CHK("restart delay", 1'b1, c >= 30 && c <= 34)
      rd(`WDT_ADDR_CLKSEL, d);
      `CHK("select kept", 8'h40, d)
   endtask

   // Interrupt gated by its own enable, reset function off
   task automatic t_gate();
      wr(`WDT_ADDR_XIE, 8'h00);
      wr(`WDT_ADDR_CLKSEL, 8'h00);
      unlock_wr(8'h01);
      repeat (16 + EARLY + 10) @(negedge MCLK);
      `CHK("irq masked", 1'b0, WDT_IRQ)
      `CHK("no cpu reset", 1'b0, WDT_CPU_RESET)
      rd(`WDT_ADDR_CTRL, d);
      `CHK("irq flag", 1'b1, d[3])
      wr(`WDT_ADDR_XIE, 8'h40);
      `CHK("irq enabled", 1'b1, WDT_IRQ)
      `CHK("wake", 1'b1, WDT_WAKE)
      wr(`WDT_ADDR_CTRL, 8'h00);
      `CHK("irq cleared", 1'b0, WDT_IRQ)
   endtask

   initial begin
      repeat (8) @(negedge MCLK);
      RST = 1'b0;
      t_reset();
      t_lock();
      t_timeout();
      t_restart();
      t_gate();
      give_verdict();
   end
endmodule
